// File: common/pucr_regs.vh
/*
 header of constants for the configuration and control register bank:
 internal addresses, field positions, reset values and timing counts.
 assumes inclusion by bare name from design files.
*/
`ifndef PUCR_REGS_VH
`define PUCR_REGS_VH

// internal addresses
`define PUCR_ADDR_PROM_CTL 8'h30
`define PUCR_ADDR_PWR_LVL 8'h31
`define PUCR_ADDR_IRQ_SUM 8'h34
`define PUCR_ADDR_ACC_EN 8'h40
`define PUCR_ADDR_SHR_EN 8'h42
`define PUCR_ADDR_CORE_CFG 8'h4C
`define PUCR_ADDR_PRESCALE 8'h50

// reset values
`define PUCR_RST_PROM_CTL 8'h00
`define PUCR_RST_PWR_LVL 8'h00
`define PUCR_RST_ACC_EN 8'h00
`define PUCR_RST_SHR_EN 8'h80
`define PUCR_RST_CORE_CFG 8'h20
`define PUCR_RST_PRESCALE 8'hF6
`define PUCR_ZERO8 8'h00

// prom control fields
`define PUCR_B_FLAG_LATE 7
`define PUCR_B_FLAG_EARLY 6
`define PUCR_B_DATA_IN 4
`define PUCR_B_CS 3
`define PUCR_B_SCLK 2
`define PUCR_B_DATA_OE 1
`define PUCR_B_DATA_OUT 0

// power level fields
`define PUCR_F_DRV_HI 5
`define PUCR_F_DRV_LO 4
`define PUCR_F_LCLK_HI 3
`define PUCR_F_LCLK_LO 2
`define PUCR_F_OSC_HI 1
`define PUCR_F_OSC_LO 0

// power state codes
`define PUCR_D0 2'b00
`define PUCR_D1 2'b01
`define PUCR_D2 2'b10
`define PUCR_D3 2'b11
`define PUCR_LVL_NEVER 2'b00
`define PUCR_LVL_D1UP 2'b01
`define PUCR_LVL_D2UP 2'b10

// shared irq enable and prescaler fields
`define PUCR_B_SHR_ON 7
`define PUCR_B_PS_HI 5
`define PUCR_B_PS_LO 2

// elapsed-time period in pci clocks
`define PUCR_ELAPSE_CYC 70

`endif

// File: src/pucr_ctl_regs.v
/*
 global configuration and control register bank of an eight-port pci uart.
 holds the prom pin control, power gating levels, irq summary, access enables,
 shared irq register enable, core config and uart clock prescaler.
 assumes a byte-wide internal bus with one-cycle write and read strobes,
 all synchronous to i_mclk; reset is the pci reset.
*/
// Overview of operation
// RQ1 - after reset release the loader drives prom select, clock and data itself; code keeps the data line released (oe_n high) during load
// RQ2 - after load, writes to 30h set prom select bit 3 and clock bit 2
// RQ3 - early elapsed flag bit 6 clears on write, sets every 70th clock
// RQ4 - late flag bit 7 clears on write, copies early flag every 70th clock
// RQ5 - bit 4 reads the present level of the prom data pin
// RQ6 - bit 1 set drives data pin with bit 0, clear tri-states it
// RQ7 - bit 0 sets the driven data level, effective only while bit 1 set
// RQ8 - pci reset clears prom control and power level registers to 00h
// RQ9 - power register holds transceiver, local clock and oscillator two-bit fields
// RQ10 - field 00 never, 01 in D1-D3, 10 in D2-D3, 11 in D3 only
// RQ11 - register 34h reads per-port interrupt status, bit n for port n
// RQ12 - register 40h bit n gates internal bus access to port n
// RQ13 - shared irq register access needs 42h bit 7; resets to 80h
// RQ14 - software keeps bit 5 of 4Ch set for correct port operation
// RQ15 - prescaler 50h bits 5 and 2 select divide by 8, 4, 2, 1
// RQ16 - prescaler resets to F6h, selecting divide by 8
// RQ17 - software should write only F6h, F2h, D6h or D2h to prescaler
// RQ18 - writes to unmapped addresses do nothing, reads return zero
// RQ19 - prom control and power registers sit in the 30h to 3Fh range
// RQ20 - timing flags driven by a free-running counter wrapping every 70 clocks
`timescale 1ns/1ps
`include "pucr_regs.vh"
module pucr_ctl_regs
#(
   parameter NPORT = 8,
   parameter LOAD_BITS = 64,
   parameter LOAD_HALF = 4
)
(
   // clock and reset
   input wire i_mclk,
   input wire i_sys_rst,
   // internal register bus
   input wire [7:0] i_addr,
   input wire i_wr,
   input wire i_rd,
   input wire [7:0] i_wdata,
   output reg [7:0] o_rdata,
   // per-port interrupt levels
   input wire [NPORT-1:0] i_port_irq,
   // current power state
   input wire [1:0] i_pwr_state,
   // prom pins
   output reg o_prom_chip_select,
   output reg o_prom_serial_clock,
   input wire i_prom_data_line,
   output reg o_prom_data_line,
   output reg o_prom_data_line_oe_n,
   // loader status and stream
   output reg o_load_done,
   output reg o_load_bit_vld,
   output reg o_load_bit,
   // element gating
   output reg o_transceiver_off,
   output reg o_local_clock_off,
   output reg o_oscillator_off,
   // uart side controls
   output reg [NPORT-1:0] o_port_access_on,
   output reg o_shared_irq_access_on,
   output reg [7:0] o_core_config,
   output reg [1:0] o_prescale_sel,
   output reg [3:0] o_prescale_div
);
   reg [7:0] prom_ctl_r;
   reg [7:0] pwr_lvl_r;
   reg [7:0] acc_en_r;
   reg [7:0] shr_en_r;
   reg [7:0] core_cfg_r;
   reg [7:0] prescale_r;
   reg [7:0] rdata_nxt;
   reg elapsed_flag_early;
   reg elapsed_flag_late;
   wire tick;
   wire ld_cs;
   wire ld_sclk;
   wire ld_data;
   wire ld_vld;
   wire ld_bit;
   wire ld_done;

   // element disabled for a given level field and power state
   function gate_off;
      input [1:0] lvl;
      input [1:0] st;
      begin
         case (lvl)
            `PUCR_LVL_NEVER: gate_off = 1'b0;
            `PUCR_LVL_D1UP: gate_off = (st != `PUCR_D0);
            `PUCR_LVL_D2UP: gate_off = (st == `PUCR_D2) || (st == `PUCR_D3);
            default: gate_off = (st == `PUCR_D3);
         endcase
      end
   endfunction

   // address hit on a write
   function wr_hit;
      input [7:0] a;
      input [7:0] target;
      input w;
      begin
         wr_hit = w && (a == target);
      end
   endfunction

   pucr_elapse_tick
   #(
      .PERIOD(`PUCR_ELAPSE_CYC),
      .CW(7)
   )
   u_tick
   (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .o_tick(tick)
   );

   pucr_prom_loader
   #(
      .NBITS(LOAD_BITS),
      .HALF(LOAD_HALF)
   )
   u_loader
   (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_data_in(i_prom_data_line),
      .o_cs(ld_cs),
      .o_sclk(ld_sclk),
      .o_data(ld_data),
      .o_bit_vld(ld_vld),
      .o_bit(ld_bit),
      .o_done(ld_done)
   );

   // register writes and elapsed flags
   always @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         prom_ctl_r <= `PUCR_RST_PROM_CTL; // RQ8
         pwr_lvl_r <= `PUCR_RST_PWR_LVL; // RQ8
         acc_en_r <= `PUCR_RST_ACC_EN;
         shr_en_r <= `PUCR_RST_SHR_EN; // RQ13
         core_cfg_r <= `PUCR_RST_CORE_CFG;
         prescale_r <= `PUCR_RST_PRESCALE; // RQ16
         elapsed_flag_early <= 1'b0;
         elapsed_flag_late <= 1'b0;
      end
      else
      begin
         if (wr_hit(i_addr, `PUCR_ADDR_PROM_CTL, i_wr))
         begin
            prom_ctl_r <= i_wdata; // RQ2 RQ19
            elapsed_flag_early <= 1'b0; // RQ3
            elapsed_flag_late <= 1'b0; // RQ4
         end
         else if (tick)
         begin
            elapsed_flag_early <= 1'b1; // RQ3
            elapsed_flag_late <= elapsed_flag_early; // RQ4
         end
         if (wr_hit(i_addr, `PUCR_ADDR_PWR_LVL, i_wr))
            pwr_lvl_r <= i_wdata; // RQ9 RQ19
         if (wr_hit(i_addr, `PUCR_ADDR_ACC_EN, i_wr))
            acc_en_r <= i_wdata; // RQ12
         if (wr_hit(i_addr, `PUCR_ADDR_SHR_EN, i_wr))
            shr_en_r <= i_wdata; // RQ13
         if (wr_hit(i_addr, `PUCR_ADDR_CORE_CFG, i_wr))
            core_cfg_r <= i_wdata; // RQ14
         if (wr_hit(i_addr, `PUCR_ADDR_PRESCALE, i_wr))
            prescale_r <= i_wdata; // RQ15
      end
   end

   // read decode, unmapped reads zero
   always @*
   begin
      rdata_nxt = `PUCR_ZERO8; // RQ18
      case (i_addr)
         `PUCR_ADDR_PROM_CTL:
         begin
            rdata_nxt = prom_ctl_r & 8'h0F;
            rdata_nxt[`PUCR_B_DATA_IN] = i_prom_data_line; // RQ5
            rdata_nxt[`PUCR_B_FLAG_EARLY] = elapsed_flag_early;
            rdata_nxt[`PUCR_B_FLAG_LATE] = elapsed_flag_late;
         end
         `PUCR_ADDR_PWR_LVL: rdata_nxt = pwr_lvl_r & 8'h3F;
         `PUCR_ADDR_IRQ_SUM: rdata_nxt = i_port_irq; // RQ11
         `PUCR_ADDR_ACC_EN: rdata_nxt = acc_en_r;
         `PUCR_ADDR_SHR_EN: rdata_nxt = shr_en_r;
         `PUCR_ADDR_CORE_CFG: rdata_nxt = core_cfg_r;
         `PUCR_ADDR_PRESCALE: rdata_nxt = prescale_r;
         default: rdata_nxt = `PUCR_ZERO8; // RQ18
      endcase
   end

   // registered outputs
   always @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_rdata <= `PUCR_ZERO8;
         o_prom_chip_select <= 1'b0;
         o_prom_serial_clock <= 1'b0;
         o_prom_data_line <= 1'b0;
         o_prom_data_line_oe_n <= 1'b1;
         o_load_done <= 1'b0;
         o_load_bit_vld <= 1'b0;
         o_load_bit <= 1'b0;
         o_transceiver_off <= 1'b0;
         o_local_clock_off <= 1'b0;
         o_oscillator_off <= 1'b0;
         o_port_access_on <= {NPORT{1'b0}};
         o_shared_irq_access_on <= 1'b1;
         o_core_config <= `PUCR_RST_CORE_CFG;
         o_prescale_sel <= 2'b11;
         o_prescale_div <= 4'h8;
      end
      else
      begin
         o_rdata <= i_rd ? rdata_nxt : `PUCR_ZERO8;
         o_load_done <= ld_done;
         o_load_bit_vld <= ld_vld;
         o_load_bit <= ld_bit;
         if (!ld_done)
         begin
            o_prom_chip_select <= ld_cs; // RQ1
            o_prom_serial_clock <= ld_sclk; // RQ1
            o_prom_data_line <= ld_data; // RQ1
            o_prom_data_line_oe_n <= 1'b1;
         end
         else
         begin
            o_prom_chip_select <= prom_ctl_r[`PUCR_B_CS]; // RQ2
            o_prom_serial_clock <= prom_ctl_r[`PUCR_B_SCLK]; // RQ2
            o_prom_data_line <= prom_ctl_r[`PUCR_B_DATA_OUT]; // RQ7
            o_prom_data_line_oe_n <= ~prom_ctl_r[`PUCR_B_DATA_OE]; // RQ6
         end
         o_transceiver_off <= gate_off(pwr_lvl_r[`PUCR_F_DRV_HI:`PUCR_F_DRV_LO],
            i_pwr_state); // RQ10
         o_local_clock_off <= gate_off(pwr_lvl_r[`PUCR_F_LCLK_HI:`PUCR_F_LCLK_LO],
            i_pwr_state); // RQ10
         o_oscillator_off <= gate_off(pwr_lvl_r[`PUCR_F_OSC_HI:`PUCR_F_OSC_LO],
            i_pwr_state); // RQ10
         o_port_access_on <= acc_en_r[NPORT-1:0]; // RQ12
         o_shared_irq_access_on <= shr_en_r[`PUCR_B_SHR_ON]; // RQ13
         o_core_config <= core_cfg_r;
         o_prescale_sel <= {prescale_r[`PUCR_B_PS_HI], prescale_r[`PUCR_B_PS_LO]};
         case ({prescale_r[`PUCR_B_PS_HI], prescale_r[`PUCR_B_PS_LO]})
            2'b11: o_prescale_div <= 4'h8; // RQ15
            2'b10: o_prescale_div <= 4'h4;
            2'b01: o_prescale_div <= 4'h2;
            default: o_prescale_div <= 4'h1;
         endcase
      end
   end
endmodule

// File: src/pucr_elapse_tick.v
/*
 free-running counter that pulses once every period of clocks.
 assumes a synchronous clock and asynchronous active-high reset.
*/
`timescale 1ns/1ps
`include "pucr_regs.vh"
module pucr_elapse_tick
#(
   parameter PERIOD = `PUCR_ELAPSE_CYC,
   parameter CW = 7
)
(
   // clock and reset
   input wire i_mclk,
   input wire i_sys_rst,
   // tick
   output reg o_tick
);
   reg [CW-1:0] cnt_r;
   wire wrap;

   assign wrap = (cnt_r == PERIOD[CW-1:0] - {{(CW-1){1'b0}}, 1'b1});

   // wrap every period, pulse on wrap
   always @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         cnt_r <= {CW{1'b0}};
         o_tick <= 1'b0;
      end
      else
      begin
         cnt_r <= wrap ? {CW{1'b0}} : cnt_r + {{(CW-1){1'b0}}, 1'b1}; // RQ20
         o_tick <= wrap; // RQ20
      end
   end
endmodule

// File: src/pucr_prom_loader.v
/*
 automatic prom loader sequencer: owns the prom pins after reset release
 for a fixed number of serial clocks, then reports done.
 assumes the prom answers on the data line; loaded data go to o_bit_vld and o_bit strobes.
*/
`timescale 1ns/1ps
module pucr_prom_loader
#(
   parameter NBITS = 64,
   parameter HALF = 4
)
(
   // clock and reset
   input wire i_mclk,
   input wire i_sys_rst,
   // prom data sampled
   input wire i_data_in,
   // pin drive
   output reg o_cs,
   output reg o_sclk,
   output reg o_data,
   // captured bit stream
   output reg o_bit_vld,
   output reg o_bit,
   // status
   output reg o_done
);
   localparam ST_RUN = 2'b00;
   localparam ST_DONE = 2'b01;

   reg [1:0] st_r;
   reg [15:0] div_r;
   reg [15:0] bits_r;

   always @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         st_r <= ST_RUN;
         div_r <= 16'h0000;
         bits_r <= 16'h0000;
         o_cs <= 1'b0;
         o_sclk <= 1'b0;
         o_data <= 1'b0;
         o_bit_vld <= 1'b0;
         o_bit <= 1'b0;
         o_done <= 1'b0;
      end
      else
      begin
         o_bit_vld <= 1'b0;
         case (st_r)
            ST_RUN:
            begin
               o_cs <= 1'b1;
               if (div_r == HALF[15:0] - 16'h0001)
               begin
                  div_r <= 16'h0000;
                  o_sclk <= ~o_sclk;
                  if (o_sclk)
                  begin
                     bits_r <= bits_r + 16'h0001;
                     if (bits_r == NBITS[15:0] - 16'h0001)
                        st_r <= ST_DONE;
                  end
                  else
                  begin
                     o_bit_vld <= 1'b1;
                     o_bit <= i_data_in;
                  end
               end
               else
                  div_r <= div_r + 16'h0001;
            end
            ST_DONE:
            begin
               o_cs <= 1'b0;
               o_sclk <= 1'b0;
               o_done <= 1'b1;
            end
            default:
               st_r <= ST_DONE;
         endcase
      end
   end
endmodule

// File: tb/pucr_ctl_chk.sv
/*
 port checker for the control register bank.
 assumes the register header on the include path; bound below.
*/
`timescale 1ns/1ps
`include "pucr_regs.vh"
module pucr_ctl_chk
#(
   parameter NPORT = 8
)
(
   // clock, reset and bus
   input wire i_mclk,
   input wire i_sys_rst,
   input wire [7:0] i_addr,
   input wire i_wr,
   input wire i_rd,
   input wire [7:0] i_wdata,
   input wire [7:0] o_rdata,
   // status inputs
   input wire [NPORT-1:0] i_port_irq,
   input wire [1:0] i_pwr_state,
   // prom pins
   input wire o_prom_chip_select,
   input wire o_prom_serial_clock,
   input wire o_prom_data_line,
   input wire o_prom_data_line_oe_n,
   input wire o_load_done,
   // controls
   input wire o_transceiver_off,
   input wire o_local_clock_off,
   input wire o_oscillator_off,
   input wire [NPORT-1:0] o_port_access_on,
   input wire o_shared_irq_access_on,
   input wire [1:0] o_prescale_sel,
   input wire [3:0] o_prescale_div
);
   wire mapped = (i_addr == `PUCR_ADDR_PROM_CTL) || (i_addr == `PUCR_ADDR_PWR_LVL) ||
      (i_addr == `PUCR_ADDR_IRQ_SUM) || (i_addr == `PUCR_ADDR_ACC_EN) ||
      (i_addr == `PUCR_ADDR_SHR_EN) || (i_addr == `PUCR_ADDR_CORE_CFG) ||
      (i_addr == `PUCR_ADDR_PRESCALE);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   // prom control write after the load
   sequence s_prom_wr;
      o_load_done && i_wr && i_addr == `PUCR_ADDR_PROM_CTL;
   endsequence
   sequence s_pin_lag;
      s_prom_wr ##2 1'b1;
   endsequence
   a_prom_pins: assert property (s_pin_lag |-> o_prom_chip_select == $past(i_wdata[3], 2) &&
      o_prom_serial_clock == $past(i_wdata[2], 2) && o_prom_data_line_oe_n == !$past(i_wdata[1], 2))
      else $error("prom pins do not follow write");
   a_data_drive: assert property (s_pin_lag |-> o_prom_data_line_oe_n ||
      o_prom_data_line == $past(i_wdata[0], 2)) else $error("prom data level wrong");
   a_load_own: assert property (!o_load_done |-> o_prom_data_line_oe_n)
      else $error("data line driven during load");
   a_rd_unmapped: assert property (i_rd && !mapped |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rd_idle: assert property (!i_rd |=> o_rdata == 8'h00) else $error("read data without read");
   a_irq_read: assert property (i_rd && i_addr == `PUCR_ADDR_IRQ_SUM |=>
      o_rdata == $past(i_port_irq)) else $error("irq summary read wrong");
   a_acc_write: assert property (i_wr && i_addr == `PUCR_ADDR_ACC_EN |-> ##2
      o_port_access_on == $past(i_wdata[NPORT-1:0], 2)) else $error("access enables wrong");
   a_shr_write: assert property (i_wr && i_addr == `PUCR_ADDR_SHR_EN |-> ##2
      o_shared_irq_access_on == $past(i_wdata[7], 2)) else $error("shared enable wrong");
   a_ps_write: assert property (i_wr && i_addr == `PUCR_ADDR_PRESCALE |-> ##2
      o_prescale_sel == {$past(i_wdata[5], 2), $past(i_wdata[2], 2)})
      else $error("prescale select wrong");
   a_ps_div: assert property (o_prescale_div == (4'h1 << o_prescale_sel))
      else $error("prescale divisor wrong");
   a_d0_on: assert property ((i_pwr_state == `PUCR_D0) [*3] |->
      !(o_transceiver_off || o_local_clock_off || o_oscillator_off)) else $error("gated in D0");
endmodule
bind pucr_ctl_regs pucr_ctl_chk #(.NPORT(NPORT)) u_pucr_ctl_chk (.i_mclk(i_mclk),
   .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata),
   .o_rdata(o_rdata), .i_port_irq(i_port_irq), .i_pwr_state(i_pwr_state),
   .o_prom_chip_select(o_prom_chip_select), .o_prom_serial_clock(o_prom_serial_clock),
   .o_prom_data_line(o_prom_data_line), .o_prom_data_line_oe_n(o_prom_data_line_oe_n),
   .o_load_done(o_load_done), .o_transceiver_off(o_transceiver_off),
   .o_local_clock_off(o_local_clock_off), .o_oscillator_off(o_oscillator_off),
   .o_port_access_on(o_port_access_on), .o_shared_irq_access_on(o_shared_irq_access_on),
   .o_prescale_sel(o_prescale_sel), .o_prescale_div(o_prescale_div));

// File: tb/pucr_prom_model.sv
/*
 serial prom stand-in on the data line.
 assumes a pull-up on the line; the device releases it with oe_n high.
*/
`timescale 1ns/1ps
module pucr_prom_model
(
   input wire i_cs,
   input wire i_sclk,
   input wire i_dev_data,
   input wire i_dev_oe_n,
   output wire o_line
);
   reg [7:0] pat_r = 8'hA5;
   // shifts a changing pattern on every clock rise, drives it only while selected
   always @(posedge i_sclk)
      pat_r <= {pat_r[6:0], ~pat_r[7]};
   // device drive wins, then the prom, else the pull-up
   assign o_line = !i_dev_oe_n ? i_dev_data : (i_cs ? pat_r[7] : 1'b1);
endmodule

// File: tb/tb.sv
/*
 self-checking bench for the control register bank.
 assumes the register header on the include path and the prom model.
*/
`timescale 1ns/1ps
`include "pucr_regs.vh"
module tb;
   reg i_mclk, i_sys_rst, i_wr, i_rd;
   reg [7:0] i_addr, i_wdata, i_port_irq, v, c;
   reg [1:0] i_pwr_state;
   reg [7:0] q_e[$];
   reg [7:0] q_m[$];
   wire [7:0] o_rdata, o_port_access_on, o_core_config;
   wire [1:0] o_prescale_sel;
   wire [3:0] o_prescale_div;
   wire cs, sclk, dout, oe_n, line, done, shr, drv_off, lclk_off, osc_off, bvld;
   integer mismatches, checked, i, s, n, nb;
   pucr_ctl_regs #(.LOAD_BITS(4), .LOAD_HALF(1)) u_pucr_ctl_regs (.i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata),
      .o_rdata(o_rdata), .i_port_irq(i_port_irq), .i_pwr_state(i_pwr_state),
      .o_prom_chip_select(cs), .o_prom_serial_clock(sclk), .i_prom_data_line(line),
      .o_prom_data_line(dout), .o_prom_data_line_oe_n(oe_n), .o_load_done(done),
      .o_load_bit_vld(bvld), .o_load_bit(), .o_transceiver_off(drv_off),
      .o_local_clock_off(lclk_off), .o_oscillator_off(osc_off),
      .o_port_access_on(o_port_access_on), .o_shared_irq_access_on(shr),
      .o_core_config(o_core_config), .o_prescale_sel(o_prescale_sel),
      .o_prescale_div(o_prescale_div));
   pucr_prom_model u_pucr_prom_model (.i_cs(cs), .i_sclk(sclk), .i_dev_data(dout),
      .i_dev_oe_n(oe_n), .o_line(line));
   initial
   begin
      i_mclk = 0;
      forever #5 i_mclk = ~i_mclk;
   end
   function off(input [1:0] l, input [1:0] st);
      off = (l != 2'b00) && (st >= l);
   endfunction
   task check(input [7:0] got, input [7:0] exp, input [7:0] m);
      checked = checked + 1;
      if ((got & ~m) !== (exp & ~m))
      begin
         mismatches = mismatches + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task results;
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task wr(input [7:0] a, input [7:0] d);
      @(posedge i_mclk);
      #1;
      i_addr = a;
      i_wdata = d;
      i_wr = 1;
      @(posedge i_mclk);
      #1;
      i_wr = 0;
   endtask
   task rd(input [7:0] a, input [7:0] e, input [7:0] m);
      @(posedge i_mclk);
      #1;
      i_addr = a;
      i_rd = 1;
      q_e.push_back(e);
      q_m.push_back(m);
      @(posedge i_mclk);
      #1;
      i_rd = 0;
   endtask
   // read answers stand for the cycle after the strobe edge
   initial
      forever
      begin
         @(posedge i_mclk);
         if (i_rd === 1'b1)
         begin
            #2;
            check(o_rdata, q_e.pop_front(), q_m.pop_front());
         end
      end
   task rst_chk;
      i_sys_rst = 1;
      repeat (4) @(posedge i_mclk);
      #1;
      i_sys_rst = 0;
      n = 0;
      nb = 0;
      while (done !== 1'b1 && n < 200)
      begin
         @(posedge i_mclk);
         if (bvld === 1'b1)
            nb = nb + 1;
         n = n + 1;
      end
      if (n >= 200)
      begin
         mismatches = mismatches + 1;
         $display("wrong value at %0t: loader never finished", $time);
         results;
      end
      check(nb[7:0], 8'h04, 8'h00);
      rd(`PUCR_ADDR_PROM_CTL, 8'h10, 8'h00);
      rd(`PUCR_ADDR_PWR_LVL, 8'h00, 8'h00);
      rd(`PUCR_ADDR_IRQ_SUM, i_port_irq, 8'h00);
      rd(`PUCR_ADDR_ACC_EN, `PUCR_RST_ACC_EN, 8'h00);
      rd(`PUCR_ADDR_CORE_CFG, `PUCR_RST_CORE_CFG, 8'h00);
      rd(`PUCR_ADDR_PRESCALE, 8'hF6, 8'h00);
      check({4'h0, o_prescale_div}, 8'h08, 8'h00);
      for (i = 0; i < 4; i = i + 1)
      begin
         c = (i == 0) ? 8'h00 : (i == 1) ? 8'h35 : (i == 2) ? 8'h41 : 8'hFF;
         wr(c, 8'hFF);
         rd(c, 8'h00, 8'h00);
      end
      rd(`PUCR_ADDR_SHR_EN, 8'h80, 8'h00);
   endtask
   initial
   begin
      i_sys_rst = 1;
      i_wr = 0;
      i_rd = 0;
      i_addr = 8'h00;
      i_wdata = 8'h00;
      i_pwr_state = 2'b00;
      mismatches = 0;
      checked = 0;
      v = $urandom(62845);
      i_port_irq = $urandom;
      rst_chk;
      for (i = 0; i < 16; i = i + 1)
      begin
         wr(`PUCR_ADDR_PROM_CTL, i[7:0]);
         repeat (3) @(posedge i_mclk);
         rd(`PUCR_ADDR_PROM_CTL, {3'b000, i[1] ? i[0] : 1'b1, i[3:0]},
            (!i[1] && i[3]) ? 8'h50 : 8'h40);
      end
      wr(`PUCR_ADDR_PROM_CTL, 8'h00);
      repeat (150) @(posedge i_mclk);
      rd(`PUCR_ADDR_PROM_CTL, 8'hD0, 8'h00);
      for (i = 3; i >= 0; i = i - 1)
      begin
         c = {2'b11, i[1], 2'b10, i[0], 2'b10};
         wr(`PUCR_ADDR_PRESCALE, c);
         rd(`PUCR_ADDR_PRESCALE, c, 8'h00);
         check({4'h0, o_prescale_div}, 8'h01 << i, 8'h00);
      end
      repeat (6)
      begin
         v = $urandom;
         wr(`PUCR_ADDR_PWR_LVL, v);
         rd(`PUCR_ADDR_PWR_LVL, v & 8'h3F, 8'h00);
         wr(`PUCR_ADDR_ACC_EN, v);
         rd(`PUCR_ADDR_ACC_EN, v, 8'h00);
         check(o_port_access_on, v, 8'h00);
         wr(`PUCR_ADDR_SHR_EN, v);
         rd(`PUCR_ADDR_SHR_EN, v, 8'h7F);
         check({7'h00, shr}, {7'h00, v[7]}, 8'h00);
         wr(`PUCR_ADDR_CORE_CFG, v | 8'h20);
         rd(`PUCR_ADDR_CORE_CFG, v | 8'h20, 8'h00);
         check(o_core_config, v | 8'h20, 8'h00);
         i_port_irq = $urandom;
         rd(`PUCR_ADDR_IRQ_SUM, i_port_irq, 8'h00);
         for (s = 0; s < 4; s = s + 1)
         begin
            @(posedge i_mclk);
            #1;
            i_pwr_state = s[1:0];
            repeat (3) @(posedge i_mclk);
            #1;
            check({5'b0, drv_off, lclk_off, osc_off}, {5'b0, off(v[5:4], s[1:0]),
               off(v[3:2], s[1:0]), off(v[1:0], s[1:0])}, 8'h00);
         end
      end
      rst_chk;
      results;
   end
endmodule
